// ---- core/sms_map.svh ----
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// Rates
`define SMS_SYS_HZ          25000000
`define SMS_SCLK_MIN_HZ     125000

// Half-period divisor minus one at the floor rate
`define SMS_DIV_MAX ((`SMS_SYS_HZ + 2*`SMS_SCLK_MIN_HZ - 1) / (2*`SMS_SCLK_MIN_HZ) - 1)
`define SMS_DIV_W           8

// Widths, depth and ceiling
`define SMS_WORD_W          32
`define SMS_BYTE_W          8
`define SMS_FIFO_DEPTH      16
`define SMS_FIFO_MAX        255
`define SMS_LEVEL_W         9

// Reset value and time-out width
`define SMS_SEL_IDLE        3'h7
`define SMS_TO_W            16

// Slave event flag positions
`define SMS_IRQ_RXNE        0
`define SMS_IRQ_TXE         1
`define SMS_IRQ_RXTH        2
`define SMS_IRQ_TXTH        3
`define SMS_IRQ_TXOV        4
`define SMS_IRQ_RXUN        5
`define SMS_IRQ_TXUN        6
`define SMS_IRQ_RXTO        7
`define SMS_IRQ_N           8

`endif

// ---- core/sms_pkg.sv ----
package sms_pkg;
  // Master transaction sequencer
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_SETUP,
    MS_RUN,
    MS_HOLD
  } sms_mst_state_t;
endpackage

// ---- core/sms_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.svh"

interface sms_fifo_if #(
  parameter int WIDTH = `SMS_BYTE_W
);
  logic                    wr_valid;
  logic                    wr_ready;
  logic [WIDTH-1:0]        wr_data;
  logic                    rd_valid;
  logic                    rd_ready;
  logic [WIDTH-1:0]        rd_data;
  logic [`SMS_LEVEL_W-1:0] level;

  modport store (input wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data, level);
  modport user  (output wr_valid, wr_data, rd_ready,
                 input wr_ready, rd_valid, rd_data, level);
endinterface
`default_nettype wire

// ---- core/sms_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.svh"

module sms_fifo #(
  parameter int WIDTH = `SMS_BYTE_W,
  parameter int DEPTH = `SMS_FIFO_DEPTH
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  sms_fifo_if.store q
);
  localparam int PW = $clog2(DEPTH);

  // Level must fit its field and the ceiling
  if (DEPTH < 2 || DEPTH > `SMS_FIFO_MAX || WIDTH < 1) begin : g_bad
    $error("sms_fifo: DEPTH must be 2..255");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_ff;
  logic [PW-1:0]    rp_ff;
  logic [PW:0]      cnt_ff;
  logic [PW:0]      nxt_cnt;
  logic             full_n_ff;
  logic             out_v_ff;
  logic [WIDTH-1:0] out_d_ff;
  logic             do_wr;
  logic             do_ld;

  // Reader sees a flop, not the array
  assign do_wr      = q.wr_valid & full_n_ff;
  assign do_ld      = (cnt_ff != '0) & (~out_v_ff | q.rd_ready);
  assign nxt_cnt    = cnt_ff + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_ld};
  assign q.wr_ready = full_n_ff;
  assign q.rd_valid = out_v_ff;
  assign q.rd_data  = out_d_ff;
  assign q.level    = `SMS_LEVEL_W'(cnt_ff) + `SMS_LEVEL_W'(out_v_ff);

  // Storage array, written only when there is room
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[wp_ff] <= q.wr_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (do_wr) begin
        wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
      end
      if (do_ld) begin
        rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
      end
    end
  end

  // Fill count and registered full flag
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff    <= '0;
      full_n_ff <= 1'b1;
    end else begin
      cnt_ff    <= nxt_cnt;
      // Output register counts too, so DEPTH words in all
      full_n_ff <= (nxt_cnt + (PW+1)'(do_ld | (out_v_ff & ~q.rd_ready)))
                   != (PW+1)'(DEPTH);
    end
  end

  // Show-ahead output register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_v_ff <= 1'b0;
      out_d_ff <= '0;
    end else if (do_ld) begin
      out_v_ff <= 1'b1;
      out_d_ff <= mem[rp_ff];
    end else if (q.rd_ready) begin
      out_v_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- core/sms_div.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.svh"

module sms_div #(
  parameter int W = `SMS_DIV_W
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_half,
  output logic              o_tick
);
  if (W < 1) begin : g_bad
    $error("sms_div: W must be positive");
  end

  logic [W-1:0] cnt_ff;

  // Pulse every i_half+1 cycles
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (cnt_ff >= i_half) begin
      cnt_ff <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- core/sms_top.sv ----
// How it works
// - Divider sets the serial clock, 125 kHz floor.
// - Master shifts 1 to 32 bits per start.
// - Polarity and phase pick all four clock modes.
// - Launch on the phase edge, sample on the other.
// - Three active-low selects, two at most asserted.
// - Auto frames each transfer; manual holds selects.
// - LSB first or MSB first per transfer.
// - Words may be byte swapped.
// - Completion sets sticky done and a maskable interrupt.
// - Until enabled, master pins float with pull-ups.
// - Bits received equal bits sent, readable after.
// - Optional sampling half a serial period late.
// - Configure, select, then load and shift.
// - Selects active low; manual selects stay low.
// - Slave accepts serial clock up to 8 MHz.
// - Slave moves bytes; far master deselects per byte.
// - Slave FIFOs buffer up to 255 bytes each way.
// - Slave samples on rising clock, mode zero only.
// - Eight individually maskable slave event flags.
// - Receive time-out flags when data stops.
// - Slave shifts only while select is low.
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.svh"

module sms_top
  import sms_pkg::*;
#(
  parameter int FIFO_DEPTH = `SMS_FIFO_DEPTH
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  // Master configuration and data
  input  wire logic                  i_mst_enable,
  input  wire logic                  i_mst_cpol,
  input  wire logic                  i_mst_cpha,
  input  wire logic                  i_mst_lsb_first,
  input  wire logic                  i_mst_big_endian,
  input  wire logic                  i_mst_delay_sample,
  input  wire logic                  i_mst_auto_sel,
  input  wire logic [2:0]            i_mst_sel_mask,
  input  wire logic [`SMS_DIV_W-1:0] i_mst_div,
  input  wire logic [4:0]            i_mst_len,
  input  wire logic [31:0]           i_mst_tx_data,
  input  wire logic                  i_mst_start,
  input  wire logic                  i_mst_done_clr,
  input  wire logic                  i_mst_irq_en,
  output logic [31:0]                o_mst_rx_data,
  output logic                       o_mst_busy,
  output logic                       o_mst_done,
  output logic                       o_mst_irq,
  // Master pins
  output logic                       o_master_serial_clock,
  output logic                       o_master_serial_clock_oe,
  output logic                       o_master_data_out,
  output logic                       o_master_data_out_oe,
  input  wire logic                  i_master_data_in,
  output logic                       o_master_select_0_n,
  output logic                       o_master_select_1_n,
  output logic                       o_master_select_2_n,
  output logic                       o_master_select_oe,
  output logic                       o_master_pullup_en,
  // Slave configuration and status
  input  wire logic                  i_slv_enable,
  input  wire logic                  i_slv_lsb_first,
  input  wire logic [7:0]            i_slv_rx_thresh,
  input  wire logic [7:0]            i_slv_tx_thresh,
  input  wire logic [`SMS_TO_W-1:0]  i_slv_timeout,
  input  wire logic [`SMS_IRQ_N-1:0] i_slv_irq_mask,
  input  wire logic [`SMS_IRQ_N-1:0] i_slv_irq_clr,
  output logic [`SMS_IRQ_N-1:0]      o_slv_irq_flags,
  output logic                       o_slv_irq,
  // Slave data streams
  input  wire logic [7:0]            i_slv_tx_data,
  input  wire logic                  i_slv_tx_valid,
  output logic                       o_slv_tx_ready,
  output logic [7:0]                 o_slv_rx_data,
  output logic                       o_slv_rx_valid,
  input  wire logic                  i_slv_rx_ready,
  // Slave pins
  input  wire logic                  i_slave_serial_clock,
  input  wire logic                  i_slave_select_in_n,
  input  wire logic                  i_slave_data_in,
  output logic                       o_slave_data_out,
  output logic                       o_slave_data_out_oe
);
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > `SMS_FIFO_MAX) begin : g_bad
    $error("sms_top: FIFO_DEPTH must be 2..255");
  end

  // Byte swap for load and result
  function automatic logic [31:0] sms_swap(input logic [31:0] w,
                                           input logic        en);
    sms_swap = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  localparam logic [`SMS_DIV_W-1:0] DIV_MAX = `SMS_DIV_W'(`SMS_DIV_MAX);

  // Master
  sms_mst_state_t    st_ff;
  logic [`SMS_DIV_W-1:0] half;
  logic              tick;
  logic [5:0]        edge_ff;
  logic [31:0]       tx_sh_ff;
  logic [31:0]       rx_sh_ff;
  logic [31:0]       rx_cap;
  logic [31:0]       rx_aligned;
  logic              pend_ff;
  logic              leading;
  logic              sample_now;
  logic              launch_now;
  logic              cap_now;
  logic              fin;
  logic [4:0]        sa;
  logic [2:0]        sel_lim;
  logic              sel_act;

  // Clamp keeps the floor rate
  assign half = (i_mst_div > DIV_MAX) ? DIV_MAX : i_mst_div;

  sms_div #(
    .W (`SMS_DIV_W)
  ) u_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (st_ff != MS_IDLE),
    .i_half    (half),
    .o_tick    (tick)
  );

  // Edge bookkeeping; even edge counts are leading edges
  assign leading    = ~edge_ff[0];
  assign sample_now = (st_ff == MS_RUN) & tick & (leading ^ i_mst_cpha);
  assign launch_now = tick & (((st_ff == MS_SETUP) & ~i_mst_cpha) |
                     ((st_ff == MS_RUN) & ~(leading ^ i_mst_cpha)));
  assign cap_now    = i_mst_delay_sample ? (pend_ff & tick) : sample_now;
  assign fin        = (st_ff == MS_HOLD) & tick;
  assign sa         = ~i_mst_len; // 31 minus i_mst_len

  // Received bit enters at the far end
  always_comb begin
    rx_cap = rx_sh_ff;
    if (cap_now) begin
      rx_cap = i_mst_lsb_first ? {i_master_data_in, rx_sh_ff[31:1]}
                               : {rx_sh_ff[30:0], i_master_data_in};
    end
    rx_aligned = i_mst_lsb_first ? (rx_cap >> sa) : rx_cap;
  end

  // Sequencer: setup half period, 2N edges, hold half period
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_ff   <= MS_IDLE;
      edge_ff <= '0;
    end else if (!i_mst_enable) begin
      st_ff   <= MS_IDLE;
      edge_ff <= '0;
    end else begin
      case (st_ff)
        MS_IDLE: begin
          edge_ff <= '0;
          if (i_mst_start) begin
            st_ff <= MS_SETUP;
          end
        end
        MS_SETUP: begin
          if (tick) begin
            st_ff <= MS_RUN;
          end
        end
        MS_RUN: begin
          if (tick) begin
            edge_ff <= edge_ff + 1'b1;
            if (edge_ff == {i_mst_len, 1'b1}) begin
              st_ff <= MS_HOLD;
            end
          end
        end
        MS_HOLD: begin
          if (tick) begin
            st_ff <= MS_IDLE;
          end
        end
        default: begin
          st_ff <= MS_IDLE;
        end
      endcase
    end
  end

  // Clock rests at polarity, toggles per tick in MS_RUN
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_master_serial_clock <= 1'b0;
    end else if (st_ff == MS_RUN && tick) begin
      o_master_serial_clock <= ~o_master_serial_clock;
    end else if (st_ff == MS_IDLE) begin
      o_master_serial_clock <= i_mst_cpol;
    end
  end

  // Transmit shifter, first bit at the exit
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_sh_ff          <= '0;
      o_master_data_out <= 1'b0;
    end else if (st_ff == MS_IDLE && i_mst_start && i_mst_enable) begin
      tx_sh_ff <= i_mst_lsb_first ? sms_swap(i_mst_tx_data, i_mst_big_endian)
                : (sms_swap(i_mst_tx_data, i_mst_big_endian) << sa);
    end else if (launch_now) begin
      o_master_data_out <= i_mst_lsb_first ? tx_sh_ff[0] : tx_sh_ff[31];
      tx_sh_ff <= i_mst_lsb_first ? {1'b0, tx_sh_ff[31:1]}
                                  : {tx_sh_ff[30:0], 1'b0};
    end
  end

  // Delayed sample waits one tick
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_sh_ff <= '0;
      pend_ff  <= 1'b0;
    end else if (st_ff == MS_IDLE) begin
      rx_sh_ff <= '0;
      pend_ff  <= 1'b0;
    end else begin
      rx_sh_ff <= rx_cap;
      if (sample_now && i_mst_delay_sample) begin
        pend_ff <= 1'b1;
      end else if (cap_now) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // Result, busy, sticky done; completion beats a clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mst_rx_data <= '0;
      o_mst_busy    <= 1'b0;
      o_mst_done    <= 1'b0;
      o_mst_irq     <= 1'b0;
    end else begin
      o_mst_busy <= (st_ff != MS_IDLE) && i_mst_enable &&
                    !(fin && (st_ff == MS_HOLD));
      if (fin) begin
        o_mst_rx_data <= sms_swap(rx_aligned, i_mst_big_endian);
      end
      o_mst_done <= fin | (o_mst_done & ~i_mst_done_clr);
      o_mst_irq  <= (fin | (o_mst_done & ~i_mst_done_clr)) & i_mst_irq_en;
    end
  end

  // A third select request drops the highest
  assign sel_lim = (i_mst_sel_mask == 3'h7) ? 3'h3 : i_mst_sel_mask;
  // Auto frames the transfer; manual follows the mask alone
  assign sel_act = i_mst_auto_sel ? (st_ff != MS_IDLE) : 1'b1;

  // Pull-ups until enabled
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      {o_master_select_2_n, o_master_select_1_n, o_master_select_0_n}
        <= `SMS_SEL_IDLE;
      o_master_serial_clock_oe <= 1'b0;
      o_master_data_out_oe     <= 1'b0;
      o_master_select_oe       <= 1'b0;
      o_master_pullup_en       <= 1'b1;
    end else begin
      {o_master_select_2_n, o_master_select_1_n, o_master_select_0_n}
        <= i_mst_enable ? ~(sel_lim & {3{sel_act}}) : `SMS_SEL_IDLE;
      o_master_serial_clock_oe <= i_mst_enable;
      o_master_data_out_oe     <= i_mst_enable;
      o_master_select_oe       <= i_mst_enable;
      o_master_pullup_en       <= ~i_mst_enable;
    end
  end

  // Slave
  sms_fifo_if #(.WIDTH(`SMS_BYTE_W)) txq ();
  sms_fifo_if #(.WIDTH(`SMS_BYTE_W)) rxq ();

  sms_fifo #(
    .WIDTH (`SMS_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .q         (txq)
  );

  sms_fifo #(
    .WIDTH (`SMS_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rxq (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .q         (rxq)
  );

  logic                 sclk_prev_ff;
  logic                 sel_prev_ff;
  logic                 rise;
  logic                 fall;
  logic                 sel_fall;
  logic [7:0]           s_tx_ff;
  logic [7:0]           s_rx_ff;
  logic [7:0]           s_rx_byte;
  logic [2:0]           s_bit_ff;
  logic                 push_ff;
  logic [7:0]           push_d_ff;
  logic [`SMS_TO_W-1:0] to_ff;
  logic                 to_evt;
  logic [`SMS_IRQ_N-1:0] set;
  logic [`SMS_IRQ_N-1:0] nxt_flags;

  // Pins are synchronous; one delay gives the edges
  assign sel_fall = i_slv_enable & ~i_slave_select_in_n & sel_prev_ff;
  assign rise = i_slv_enable & ~i_slave_select_in_n &
                i_slave_serial_clock & ~sclk_prev_ff;
  assign fall = i_slv_enable & ~i_slave_select_in_n &
                ~i_slave_serial_clock & sclk_prev_ff;
  assign s_rx_byte = i_slv_lsb_first ? {i_slave_data_in, s_rx_ff[7:1]}
                                     : {s_rx_ff[6:0], i_slave_data_in};

  // Full receive FIFO drops bytes: the far master cannot wait
  assign txq.wr_valid = i_slv_tx_valid;
  assign txq.wr_data  = i_slv_tx_data;
  assign txq.rd_ready = sel_fall;
  assign rxq.wr_valid = push_ff;
  assign rxq.wr_data  = push_d_ff;
  assign rxq.rd_ready = i_slv_rx_ready;
  assign o_slv_tx_ready = txq.wr_ready;
  assign o_slv_rx_valid = rxq.rd_valid;
  assign o_slv_rx_data  = rxq.rd_data;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev_ff <= 1'b0;
      sel_prev_ff  <= 1'b1;
    end else begin
      sclk_prev_ff <= i_slave_serial_clock;
      sel_prev_ff  <= i_slave_select_in_n;
    end
  end

  // Load at select fall, sample on rise, launch on fall
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_tx_ff          <= '0;
      s_rx_ff          <= '0;
      s_bit_ff         <= '0;
      push_ff          <= 1'b0;
      push_d_ff        <= '0;
      o_slave_data_out <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      if (sel_fall) begin
        s_bit_ff <= '0;
        s_tx_ff  <= txq.rd_valid ? txq.rd_data : 8'h00;
        o_slave_data_out <= txq.rd_valid ?
          (i_slv_lsb_first ? txq.rd_data[0] : txq.rd_data[7]) : 1'b0;
      end else if (rise) begin
        s_rx_ff  <= s_rx_byte;
        s_bit_ff <= s_bit_ff + 1'b1;
        if (s_bit_ff == 3'h7) begin
          push_ff   <= 1'b1;
          push_d_ff <= s_rx_byte;
        end
      end else if (fall) begin
        s_tx_ff <= i_slv_lsb_first ? {1'b0, s_tx_ff[7:1]}
                                   : {s_tx_ff[6:0], 1'b0};
        o_slave_data_out <= i_slv_lsb_first ? s_tx_ff[1] : s_tx_ff[6];
      end
    end
  end

  // Drive the return line only while selected
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_slave_data_out_oe <= 1'b0;
    end else begin
      o_slave_data_out_oe <= i_slv_enable & ~i_slave_select_in_n;
    end
  end

  // Time-out counter; zero period disables it
  assign to_evt = i_slv_enable && (i_slv_timeout != '0) && !push_ff &&
                  rxq.rd_valid && (to_ff == i_slv_timeout - 1'b1);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      to_ff <= '0;
    end else if (push_ff || rxq.level == '0) begin
      to_ff <= '0;
    end else if (to_ff != i_slv_timeout) begin
      to_ff <= to_ff + 1'b1;
    end
  end

  // A set in the clear cycle survives
  always_comb begin
    set                = '0;
    set[`SMS_IRQ_RXNE] = rxq.level != '0;
    set[`SMS_IRQ_TXE]  = txq.level == '0;
    set[`SMS_IRQ_RXTH] = rxq.level > {1'b0, i_slv_rx_thresh};
    set[`SMS_IRQ_TXTH] = txq.level < {1'b0, i_slv_tx_thresh};
    set[`SMS_IRQ_TXOV] = i_slv_tx_valid & ~txq.wr_ready;
    set[`SMS_IRQ_RXUN] = i_slv_rx_ready & ~rxq.rd_valid;
    set[`SMS_IRQ_TXUN] = sel_fall & ~txq.rd_valid;
    set[`SMS_IRQ_RXTO] = to_evt;
    set       = set & {`SMS_IRQ_N{i_slv_enable}};
    nxt_flags = (o_slv_irq_flags & ~i_slv_irq_clr) | set;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_slv_irq_flags <= '0;
      o_slv_irq       <= 1'b0;
    end else begin
      o_slv_irq_flags <= nxt_flags;
      o_slv_irq       <= |(nxt_flags & i_slv_irq_mask);
    end
  end
endmodule
`default_nettype wire

// ---- dv/sms_spi_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far slave: echoes and logs
module sms_spi_peer (
  input  wire logic        sclk, mosi, sel_n,
  output logic             miso,
  output logic [31:0]      cap
);
  logic hold = 1'b1;
  // Released line shows the inverse
  always @(posedge sel_n) hold <= ~mosi;
  assign miso = sel_n ? hold : mosi;
  // Rising-edge log while selected
  always @(posedge sclk) if (!sel_n) cap <= {cap[30:0], mosi};
endmodule
`default_nettype wire

// ---- dv/sms_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port watch
module sms_top_checker (
  input wire logic       i_clk_sys, i_rst, i_mst_enable, i_mst_cpol,
  input wire logic       i_mst_irq_en, o_mst_busy, o_mst_done, o_mst_irq,
  input wire logic       o_master_serial_clock, o_master_serial_clock_oe,
  input wire logic       o_master_pullup_en, o_master_select_0_n,
  input wire logic       o_master_select_1_n, o_master_select_2_n,
  input wire logic       i_slave_select_in_n, o_slave_data_out_oe,
  input wire logic       i_slv_tx_valid, o_slv_tx_ready, o_slv_rx_valid,
  input wire logic       i_slv_rx_ready,
  input wire logic [7:0] i_mst_div, o_slv_irq_flags, o_slv_rx_data
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Divisor two: three cycles high
  sequence s_rise;
    $rose(o_master_serial_clock) && !i_mst_cpol && i_mst_div == 8'h02;
  endsequence
  sequence s_high3;
    o_master_serial_clock [*3] ##1 !o_master_serial_clock;
  endsequence
  property p_half; s_rise |-> s_high3; endproperty
  a_half: assert property (p_half)
    else $error("serial half period wrong");
  property p_done;
    $rose(o_mst_busy) && i_mst_div == 8'h00 |-> ##[3:120] $rose(o_mst_done);
  endproperty
  a_done: assert property (p_done)
    else $error("transfer did not finish");
  property p_pull;
    !i_mst_enable |=> o_master_pullup_en && !o_master_serial_clock_oe;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pins driven while off");
  property p_two;
    o_master_select_0_n || o_master_select_1_n || o_master_select_2_n;
  endproperty
  a_two: assert property (p_two)
    else $error("three selects low");
  property p_irq; (o_mst_done && i_mst_irq_en) [*2] |-> o_mst_irq; endproperty
  a_irq: assert property (p_irq)
    else $error("done without interrupt");
  property p_soe; i_slave_select_in_n [*2] |-> !o_slave_data_out_oe; endproperty
  a_soe: assert property (p_soe)
    else $error("slave drives unselected");
  // Index 4 is the transmit overflow flag
  property p_txov; i_slv_tx_valid && !o_slv_tx_ready |=> o_slv_irq_flags[4];
  endproperty
  a_txov: assert property (p_txov)
    else $error("overflow flag missing");
  property p_hold;
    o_slv_rx_valid && !i_slv_rx_ready |=> o_slv_rx_valid && $stable(o_slv_rx_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("receive byte dropped");
endmodule
bind sms_top sms_top_checker u_chk (.*);
`default_nettype wire

// ---- dv/sms_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sms_top_bench;
  logic i_clk_sys = 0, i_rst = 1, i_mst_enable, i_mst_cpol, i_mst_cpha;
  logic i_mst_lsb_first, i_mst_big_endian, i_mst_delay_sample, i_mst_start;
  logic i_mst_auto_sel, i_mst_done_clr, i_mst_irq_en, i_master_data_in;
  logic i_slv_enable, i_slv_lsb_first, i_slv_tx_valid, i_slv_rx_ready;
  logic i_slave_serial_clock, i_slave_select_in_n, i_slave_data_in;
  logic o_mst_busy, o_mst_done, o_mst_irq, o_master_serial_clock;
  logic o_master_serial_clock_oe, o_master_data_out, o_master_data_out_oe;
  logic o_master_select_0_n, o_master_select_1_n, o_master_select_2_n;
  logic o_master_select_oe, o_master_pullup_en, o_slv_irq, o_slv_tx_ready;
  logic o_slv_rx_valid, o_slave_data_out, o_slave_data_out_oe;
  logic [2:0] i_mst_sel_mask;
  logic [4:0] i_mst_len;
  logic [7:0] i_mst_div, i_slv_rx_thresh, i_slv_tx_thresh, i_slv_irq_mask;
  logic [7:0] i_slv_irq_clr, i_slv_tx_data, o_slv_irq_flags, o_slv_rx_data;
  logic [7:0] g, q[$];
  logic [15:0] i_slv_timeout;
  logic [31:0] i_mst_tx_data, o_mst_rx_data, cap, r, d, m, seed = 32'hD81A;
  int mismatches = 0, checks = 0, n;
  // Undriven pins float high
  wire [2:0] sels = {o_master_select_2_n, o_master_select_1_n, o_master_select_0_n};
  wire sk = o_master_serial_clock_oe ? o_master_serial_clock : 1'b1;
  wire mo = o_master_data_out_oe ? o_master_data_out : 1'b1;
  wire s0 = o_master_select_oe ? o_master_select_0_n : 1'b1;
  sms_top DUT (.*);
  sms_spi_peer u_peer (.sclk(sk), .mosi(mo), .sel_n(s0),
                       .miso(i_master_data_in), .cap(cap));
  always #20 i_clk_sys = ~i_clk_sys;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] rev(input logic [31:0] w, input int k);
    rev = '0;
    for (int i = 0; i <= k; i++) rev[k - i] = w[i];
  endfunction
  task automatic check(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic hang();
    mismatches++;
    print_verdict();
  endtask
  // Clear, start, bounded wait
  task automatic xfer(input logic [4:0] len, input logic [31:0] v);
    i_mst_done_clr = 1;
    tick();
    {i_mst_done_clr, i_mst_len, i_mst_tx_data, i_mst_start} = {1'b0, len, v, 1'b1};
    tick();
    i_mst_start = 0;
    for (n = 0; n < 400 && o_mst_done !== 1'b1; n++) tick();
    if (o_mst_done !== 1'b1) hang();
    tick();
  endtask
  // Mode 0 byte, six cycles a bit
  task automatic sbyte(input logic [7:0] v, output logic [7:0] o);
    i_slave_select_in_n = 0;
    for (int j = 0; j < 8; j++) begin
      i_slave_data_in = v[i_slv_lsb_first ? j : 7 - j];
      repeat (3) tick();
      o[i_slv_lsb_first ? j : 7 - j] = o_slave_data_out;
      i_slave_serial_clock = 1;
      repeat (3) tick();
      i_slave_serial_clock = 0;
    end
    repeat (2) tick();
    i_slave_select_in_n = 1;
    i_slave_data_in = ~i_slave_data_in;
    repeat (3) tick();
  endtask
  initial begin
    {i_mst_enable, i_mst_cpol, i_mst_cpha, i_mst_lsb_first, i_mst_big_endian,
     i_mst_delay_sample, i_mst_start, i_mst_done_clr, i_mst_irq_en, i_slv_enable,
     i_slv_lsb_first, i_slv_tx_valid, i_slv_rx_ready, i_slave_serial_clock,
     i_slave_data_in, i_mst_len, i_mst_tx_data, i_mst_div, i_slv_irq_mask,
     i_slv_irq_clr, i_slv_tx_data} = '0;
    {i_mst_auto_sel, i_slave_select_in_n, i_mst_sel_mask} = 5'h19;
    {i_slv_timeout, i_slv_rx_thresh, i_slv_tx_thresh} = 32'h0050_0804;
    repeat (8) @(posedge i_clk_sys);
    check({o_master_pullup_en, o_master_select_oe, o_master_serial_clock_oe}, 4);
    #1 i_rst = 0;
    tick();
    {i_mst_enable, i_slv_enable} = 2'h3;
    // Random transfers, shortest and longest first
    for (int i = 0; i < 14; i++) begin
      r = rnd();
      {i_mst_cpol, i_mst_cpha, i_mst_lsb_first, i_mst_delay_sample} = r[3:0];
      {i_mst_div, i_mst_irq_en} = {6'h00, r[5:4], r[6]};
      r[11:7] = i == 0 ? 5'h00 : i == 1 ? 5'h1F : r[11:7];
      i_mst_big_endian = r[12] & (r[11:7] == 5'h1F);
      d = rnd();
      xfer(r[11:7], d);
      m = ~(32'hFFFFFFFE << r[11:7]);
      check(o_mst_rx_data, d & m);
      check(o_mst_irq, i_mst_irq_en);
      check(sels, 7);
      if (i_mst_cpol == i_mst_cpha && !i_mst_big_endian)
        check(cap & m, i_mst_lsb_first ? rev(d, r[11:7]) : d & m);
    end
    {i_mst_auto_sel, i_mst_sel_mask} = 4'h7;
    repeat (2) tick();
    check(sels, 4);
    xfer(5'h07, rnd());
    check(sels, 4);
    i_mst_enable = 0;
    repeat (2) tick();
    check({o_master_pullup_en, o_master_data_out_oe, o_master_select_oe}, 4);
    // Fill until refused, plus one refused beat
    i_slv_tx_valid = 1;
    for (n = 0; n < 40 && o_slv_tx_ready; n++) begin
      r = rnd();
      i_slv_tx_data = r[7:0];
      q.push_back(r[7:0]);
      tick();
    end
    check(n, 16);
    tick();
    {i_slv_tx_valid, i_slv_irq_clr} = 9'h0FF;
    tick();
    i_slv_irq_clr = 0;
    repeat (100) tick();
    check(o_slv_irq_flags, 0);
    i_slv_irq_mask = 8'hFF;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      i_slv_lsb_first = r[8];
      sbyte(r[7:0], g);
      check(g, q.pop_front());
      q.push_back(r[7:0]);
    end
    repeat (30) tick();
    check(o_slv_irq_flags[7], 0);
    repeat (60) tick();
    check({o_slv_irq_flags[7], o_slv_irq}, 3);
    sbyte(8'hA5, g);
    check({g, o_slv_irq_flags[6]}, 1);
    // Drain; the extra byte was dropped
    foreach (q[i]) begin
      for (n = 0; n < 20 && o_slv_rx_valid !== 1'b1; n++) tick();
      if (o_slv_rx_valid !== 1'b1) hang();
      g = o_slv_rx_data;
      i_slv_rx_ready = 1;
      tick();
      i_slv_rx_ready = 0;
      tick();
      check(g, q[i]);
    end
    repeat (4) tick();
    check(o_slv_rx_valid, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
